/* hw/dlf_pkg.sv */
// Purpose: Shared constants and types of the link format register bank
// Assumes: 8-bit registers reached by the local control channel decoder
// Notes: Offsets, reset values and field positions live only here
package dlf_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] REG_RESERVED_SIX = 8'h06;
    localparam logic [7:0] REG_LINK_FORMAT = 8'h07;
    localparam logic [7:0] REG_POLARITY_ERR = 8'h08;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RESERVED_SIX_RESET = 8'h02;
    localparam logic [7:0] LINK_FORMAT_BASE = 8'h00;
    localparam logic [7:0] POLARITY_ERR_RESET = 8'h80;

    // ----------------------------------------
    // Field positions, link format register
    // ----------------------------------------
    localparam int DOUBLE_INPUT_BIT = 7;
    localparam int DATA_RATE_BIT = 6;
    localparam int BUS_WIDTH_BIT = 5;
    localparam int EDGE_SELECT_BIT = 4;
    localparam int SYNC_TRACK_BIT = 3;
    localparam int SYNC_ENCODE_BIT = 2;
    localparam int CHECK_SEL_LSB = 0;

    // ----------------------------------------
    // Field positions, polarity and error register
    // ----------------------------------------
    localparam int VS_INVERT_BIT = 7;
    localparam int HS_INVERT_BIT = 6;
    localparam int MATCHED_DBL_BIT = 4;
    localparam int STAGGER_BIT = 3;
    localparam int AUTO_CLEAR_BIT = 2;
    localparam int ERR_SEL_LSB = 0;

    // ----------------------------------------
    // Error check codes and error output selection
    // ----------------------------------------
    localparam logic [1:0] CHECK_PARITY = 2'h0;
    localparam logic [1:0] CHECK_CRC = 2'h1;
    localparam logic [1:0] CHECK_HAMMING = 2'h2;
    localparam logic [1:0] CHECK_FORBIDDEN = 2'h3;
    localparam logic [1:0] ERR_SEL_DETECTED = 2'h0;
    localparam logic [1:0] ERR_SEL_CORRECTED = 2'h1;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int AUTO_CLEAR_TIME_NS = 1000;
    localparam int AUTO_CLEAR_CYCLES_INT =
        (AUTO_CLEAR_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 :
        AUTO_CLEAR_TIME_NS / CLOCK_PERIOD_NS;
    localparam logic [15:0] AUTO_CLEAR_CYCLES =
        16'(AUTO_CLEAR_CYCLES_INT);

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic local_ctrl_channel_enable;
        logic strap_pin_zero;
        logic strap_pin_one;
        logic strap_pin_edge;
        logic strap_pin_ms;
        logic strap_pin_check;
    } dlf_strap_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wr_data;
        logic wr_en;
        logic rd_en;
    } dlf_req_t;

    typedef struct packed {
        logic double_input_select;
        logic low_data_rate;
        logic bus_width_select;
        logic output_edge_select;
        logic sync_tracking_enable;
        logic sync_encoding_enable;
        logic [1:0] error_check_select;
        logic vs_invert;
        logic hs_invert;
        logic parallel_out_bit0_invert;
        logic parallel_out_bit1_invert;
        logic matched_double_flag;
        logic stagger_disable;
    } dlf_cfg_t;

    typedef struct packed {
        logic [7:0] reserved_config_six;
        logic [7:0] link_format_config;
        logic [7:0] polarity_error_control;
        logic [7:0] detected_error_count;
        logic [7:0] corrected_error_count;
        logic [15:0] clear_timer;
        logic error_output;
        logic [7:0] rd_data;
        dlf_cfg_t cfg;
    } dlf_state_t;

endpackage : dlf_pkg

/* hw/dlf_regs.sv */
// Purpose: Link format, polarity and error control registers of a
//          serial-link video deserializer
// Assumes: Control channel decoder delivers one-cycle read/write strobes
// Notes: Error events arrive as one-cycle pulses from the link decoder
//
// What this block does
// - Bit 7 picks single or double input
// - Bit 5 picks 24 or 32 bit
// - Bit 4 picks output data clock edge
// - Bit 3 enables sync tracking, strapped reset
// - Bit 2 enables sync encoding, strapped reset
// - Check codes: 00 parity, 01 CRC
// - Code 10 Hamming; code 11 never taken
// - Check field strapped to 10 or 00
// - Polarity bit 7 inverts VS or bit0
// - Polarity bit 6 inverts HS or bit1
// - Auto clear resets counters after error
// - Error select picks detected, corrected, either
`timescale 1ns/1ns

module dlf_regs
    import dlf_pkg::*;
#(
    parameter int COUNT_W = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire dlf_strap_t straps,
    input wire dlf_req_t req,
    input wire logic detected_error_pulse,
    input wire logic corrected_error_pulse,
    input wire logic [COUNT_W-1:0] detected_error_threshold,
    input wire logic [COUNT_W-1:0] corrected_error_threshold,
    output logic [7:0] rd_data,
    output dlf_cfg_t cfg,
    output logic error_output,
    output logic [COUNT_W-1:0] detected_error_count,
    output logic [COUNT_W-1:0] corrected_error_count
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] count_inc(input logic [7:0] c,
                                             input logic ev);
        // Saturate so a stuck error source cannot wrap the count
        if (ev && c != 8'hFF) begin
            return c + 8'h01;
        end
        return c;
    endfunction : count_inc

    function automatic dlf_cfg_t decode_cfg(input logic [7:0] lf,
                                            input logic [7:0] pe);
        dlf_cfg_t c;
        c.double_input_select = lf[DOUBLE_INPUT_BIT];
        c.low_data_rate = lf[DATA_RATE_BIT];
        c.bus_width_select = lf[BUS_WIDTH_BIT];
        c.output_edge_select = lf[EDGE_SELECT_BIT];
        c.sync_tracking_enable = lf[SYNC_TRACK_BIT];
        c.sync_encoding_enable = lf[SYNC_ENCODE_BIT];
        c.error_check_select = lf[CHECK_SEL_LSB +: 2];
        c.vs_invert = pe[VS_INVERT_BIT] & lf[SYNC_ENCODE_BIT];
        c.parallel_out_bit0_invert = pe[VS_INVERT_BIT] & ~lf[SYNC_ENCODE_BIT];
        c.hs_invert = pe[HS_INVERT_BIT] & lf[SYNC_ENCODE_BIT];
        c.parallel_out_bit1_invert = pe[HS_INVERT_BIT] & ~lf[SYNC_ENCODE_BIT];
        c.matched_double_flag = pe[MATCHED_DBL_BIT];
        c.stagger_disable = pe[STAGGER_BIT];
        return c;
    endfunction : decode_cfg

    // ----------------------------------------
    // State
    // ----------------------------------------
    dlf_state_t st;
    dlf_state_t next_st;
    logic [7:0] strap_format;
    logic strap_ok;
    logic [7:0] det_now;
    logic [7:0] corr_now;
    logic det_over;
    logic corr_over;

    always_comb begin
        // Straps only count when the local channel is off
        strap_ok = ~straps.local_ctrl_channel_enable;
        strap_format = LINK_FORMAT_BASE;
        strap_format[DOUBLE_INPUT_BIT] =
            strap_ok & straps.strap_pin_zero;
        strap_format[BUS_WIDTH_BIT] =
            strap_ok & straps.strap_pin_one;
        strap_format[EDGE_SELECT_BIT] =
            strap_ok & straps.strap_pin_edge;
        strap_format[SYNC_TRACK_BIT] =
            strap_ok & straps.strap_pin_ms;
        strap_format[SYNC_ENCODE_BIT] =
            strap_ok & straps.strap_pin_ms;
        strap_format[CHECK_SEL_LSB +: 2] = (strap_ok & straps.strap_pin_check)
            ? CHECK_HAMMING : CHECK_PARITY;

        next_st = st;
        det_now = st.detected_error_count;
        corr_now = st.corrected_error_count;

        // Auto clear: timer runs while the error output stands
        if (st.polarity_error_control[AUTO_CLEAR_BIT] && st.error_output) begin
            if (st.clear_timer == AUTO_CLEAR_CYCLES - 16'h0001) begin
                det_now = 8'h00;
                corr_now = 8'h00;
                next_st.clear_timer = 16'h0000;
            end else begin
                next_st.clear_timer = st.clear_timer + 16'h0001;
            end
        end else begin
            next_st.clear_timer = 16'h0000;
        end
        // New events after a clear still count: set beats clear
        next_st.detected_error_count = count_inc(det_now,
                                                 detected_error_pulse);
        next_st.corrected_error_count = count_inc(corr_now,
                                                  corrected_error_pulse);

        if (req.wr_en) begin
            unique case (req.addr)
                REG_RESERVED_SIX: begin
                    next_st.reserved_config_six = req.wr_data;
                end
                REG_LINK_FORMAT: begin
                    next_st.link_format_config = req.wr_data;
                    // The forbidden check code keeps the old scheme
                    if (req.wr_data[CHECK_SEL_LSB +: 2] ==
                        CHECK_FORBIDDEN) begin
                        next_st.link_format_config[CHECK_SEL_LSB +: 2] =
                            st.link_format_config[1:0];
                    end
                end
                REG_POLARITY_ERR: begin
                    next_st.polarity_error_control = req.wr_data;
                end
                default: begin
                end
            endcase
        end

        if (req.rd_en) begin
            unique case (req.addr)
                REG_RESERVED_SIX: next_st.rd_data = st.reserved_config_six;
                REG_LINK_FORMAT: next_st.rd_data = st.link_format_config;
                REG_POLARITY_ERR: next_st.rd_data = st.polarity_error_control;
                default: next_st.rd_data = 8'h00;
            endcase
        end

        det_over = next_st.detected_error_count > detected_error_threshold;
        corr_over = next_st.corrected_error_count > corrected_error_threshold;
        unique case (next_st.polarity_error_control[ERR_SEL_LSB +: 2])
            ERR_SEL_DETECTED: next_st.error_output = det_over;
            ERR_SEL_CORRECTED: next_st.error_output = corr_over;
            default: next_st.error_output = det_over | corr_over;
        endcase

        if (sys_rst) begin
            next_st.reserved_config_six = RESERVED_SIX_RESET;
            next_st.link_format_config = strap_format;
            next_st.polarity_error_control = POLARITY_ERR_RESET;
            next_st.detected_error_count = 8'h00;
            next_st.corrected_error_count = 8'h00;
            next_st.clear_timer = 16'h0000;
            next_st.error_output = 1'b0;
            next_st.rd_data = 8'h00;
        end
        next_st.cfg = decode_cfg(next_st.link_format_config,
                                 next_st.polarity_error_control);
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign rd_data = st.rd_data;
    assign cfg = st.cfg;
    assign error_output = st.error_output;
    assign detected_error_count = st.detected_error_count[COUNT_W-1:0];
    assign corrected_error_count = st.corrected_error_count[COUNT_W-1:0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_double_strap: assert property (@(posedge clock)
        sys_rst |=> cfg.double_input_select ==
            $past(~straps.local_ctrl_channel_enable & straps.strap_pin_zero))
        else $error("double input reset value wrong");
    a_width_strap: assert property (@(posedge clock)
        sys_rst |=> cfg.bus_width_select ==
            $past(~straps.local_ctrl_channel_enable & straps.strap_pin_one))
        else $error("bus width reset value wrong");
    a_edge_write: assert property (@(posedge clock)
        disable iff (sys_rst)
        req.wr_en && req.addr == REG_LINK_FORMAT |=>
            cfg.output_edge_select == $past(req.wr_data[EDGE_SELECT_BIT]))
        else $error("edge select not written");
    a_sync_strap: assert property (@(posedge clock)
        sys_rst |=> cfg.sync_tracking_enable == cfg.sync_encoding_enable)
        else $error("sync straps disagree");
    a_no_forbidden: assert property (@(posedge clock)
        disable iff (sys_rst)
        cfg.error_check_select != CHECK_FORBIDDEN)
        else $error("forbidden check code held");
    a_check_strap: assert property (@(posedge clock)
        sys_rst |=> cfg.error_check_select ==
            ($past(~straps.local_ctrl_channel_enable &
                   straps.strap_pin_check) ? CHECK_HAMMING : CHECK_PARITY))
        else $error("check select reset value wrong");
    a_vs_route: assert property (@(posedge clock)
        disable iff (sys_rst)
        cfg.vs_invert |-> cfg.sync_encoding_enable && !cfg.parallel_out_bit0_invert)
        else $error("vertical invert misrouted");
    a_hs_route: assert property (@(posedge clock)
        disable iff (sys_rst)
        cfg.parallel_out_bit1_invert |-> !cfg.sync_encoding_enable && !cfg.hs_invert)
        else $error("horizontal invert misrouted");
    a_auto_clear: assert property (@(posedge clock)
        disable iff (sys_rst)
        $rose(error_output) && st.polarity_error_control[AUTO_CLEAR_BIT] &&
        !req.wr_en |-> ##[1:60] (detected_error_count == 0 ||
                                 !error_output))
        else $error("error counters not cleared in time");
    a_err_detected: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.polarity_error_control[ERR_SEL_LSB +: 2] == ERR_SEL_DETECTED |->
            error_output == (detected_error_count >
                             detected_error_threshold))
        else $error("error output disagrees with detected count");

endmodule : dlf_regs

/* tb/dlf_host.sv */
// Purpose: Host model on the local control channel of the register bank
// Assumes: One-cycle strobes launched on the falling clock edge
// Notes: Released bus shows inverted values so stale data never matches
`timescale 1ns/1ns

module dlf_host
    import dlf_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] rd_data,
    output dlf_req_t req
);
    initial req = '0;

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Callers keep 0x06 at 0x02 and reserved bits at zero
    // No pixel clock runs here, so the edge bit may change freely
    // Inversion used with single input here only with matched pairing set
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req = '{addr: a, wr_data: d, wr_en: 1'b1, rd_en: 1'b0};
        @(negedge clock);
        req = '{addr: ~a, wr_data: ~d, wr_en: 1'b0, rd_en: 1'b0};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        req = '{addr: a, wr_data: 8'hA5, wr_en: 1'b0, rd_en: 1'b1};
        @(negedge clock);
        req = '{addr: ~a, wr_data: 8'h5A, wr_en: 1'b0, rd_en: 1'b0};
        d = rd_data;
    endtask : rd
endmodule : dlf_host

/* tb/tb.sv */
// Purpose: Self-checking bench of the link format register bank
// Assumes: Straps sampled during reset, error inputs high one cycle per counted event
// Notes: Random stimulus from a fixed seed plus forced corner cases
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end

module tb;
    import dlf_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    dlf_strap_t straps = '0;
    dlf_req_t req;
    logic det_p = 1'b0;
    logic cor_p = 1'b0;
    logic [7:0] det_thr = 8'h00;
    logic [7:0] cor_thr = 8'h00;
    logic [7:0] rd_data, det_cnt, cor_cnt, v, w, ex, p;
    dlf_cfg_t cfg;
    logic err_out;
    int bad_count = 0;
    int samples_checked = 0;
    int nd, nc;
    logic e;

    initial forever #10 clock = ~clock;

    dlf_host host (.clock(clock), .rd_data(rd_data), .req(req));
    dlf_regs #(.COUNT_W(8)) dut (.clock(clock), .sys_rst(sys_rst),
        .straps(straps), .req(req), .detected_error_pulse(det_p),
        .corrected_error_pulse(cor_p), .detected_error_threshold(det_thr),
        .corrected_error_threshold(cor_thr), .rd_data(rd_data), .cfg(cfg),
        .error_output(err_out), .detected_error_count(det_cnt),
        .corrected_error_count(cor_cnt));

    // ----------------------------------------
    // Expectations and helpers
    // ----------------------------------------
    function automatic logic [7:0] exp_fmt(input dlf_strap_t s);
        if (s.local_ctrl_channel_enable)
            return 8'h00;
        return {s.strap_pin_zero, 1'b0, s.strap_pin_one, s.strap_pin_edge,
            s.strap_pin_ms, s.strap_pin_ms, s.strap_pin_check, 1'b0};
    endfunction : exp_fmt

    task automatic do_reset(input int n);
        @(negedge clock);
        sys_rst = 1'b1;
        repeat (n) @(negedge clock);
        sys_rst = 1'b0;
    endtask : do_reset

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial begin
        // Tests need well under a thousand cycles
        #100_000;
        bad_count++;
        end_sim();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(82));
        do_reset(8);
        for (int i = 0; i < 12; i++) begin
            straps = (i == 0) ? 6'h1F : 6'($urandom);
            do_reset(2);
            ex = exp_fmt(straps);
            host.rd(REG_LINK_FORMAT, v);
            `CHK("fmt_reset", ex, v)
            `CHK("cfg_reset", ex, cfg[13:6])
        end
        host.rd(REG_RESERVED_SIX, v);
        `CHK("rsvd_reset", 8'h02, v)
        host.rd(REG_POLARITY_ERR, v);
        `CHK("pol_reset", 8'h80, v)
        host.rd(8'h09, v);
        `CHK("unmapped", 8'h00, v)
        for (int i = 0; i < 10; i++) begin
            w = (i < 4) ? {6'($urandom), 2'(i)} : 8'($urandom);
            host.rd(REG_LINK_FORMAT, v);
            ex = (w[1:0] == CHECK_FORBIDDEN) ? {w[7:2], v[1:0]} : w;
            host.wr(REG_LINK_FORMAT, w);
            host.rd(REG_LINK_FORMAT, v);
            `CHK("fmt_rw", ex, v)
            `CHK("cfg_fmt", ex, cfg[13:6])
        end
        for (int i = 0; i < 6; i++) begin
            e = i[0];
            // Double input here or matched pairing keeps inversion legal
            p = {2'($urandom), 1'b0, ~e, 4'($urandom)};
            host.wr(REG_LINK_FORMAT, {e, 3'h0, 1'b1, e, 2'h0});
            host.wr(REG_POLARITY_ERR, p);
            host.rd(REG_POLARITY_ERR, v);
            `CHK("pol_rw", p, v)
            `CHK("vs_inv", p[7] & e, cfg.vs_invert)
            `CHK("parallel_out_bit0_inv", p[7] & ~e, cfg.parallel_out_bit0_invert)
            `CHK("hs_inv", p[6] & e, cfg.hs_invert)
            `CHK("parallel_out_bit1_inv", p[6] & ~e, cfg.parallel_out_bit1_invert)
            `CHK("matched", p[4], cfg.matched_double_flag)
            `CHK("stagger", p[3], cfg.stagger_disable)
        end
        for (int s = 0; s < 4; s++) begin
            do_reset(1);
            det_thr = 8'($urandom_range(0, 3));
            cor_thr = 8'($urandom_range(0, 3));
            nd = $urandom_range(0, 5);
            nc = $urandom_range(0, 5);
            host.wr(REG_POLARITY_ERR, 8'(s));
            for (int k = 0; k < 5; k++) begin
                @(negedge clock);
                det_p = (k < nd);
                cor_p = (k < nc);
            end
            @(negedge clock);
            det_p = 1'b0;
            cor_p = 1'b0;
            e = (s == 0) ? (nd > det_thr) : (s == 1) ? (nc > cor_thr) :
                ((nd > det_thr) || (nc > cor_thr));
            `CHK("err_out", e, err_out)
            `CHK("det_cnt", 8'(nd), det_cnt)
            `CHK("cor_cnt", 8'(nc), cor_cnt)
        end
        det_p = 1'b1;
        repeat (260) @(negedge clock);
        det_p = 1'b0;
        `CHK("det_sat", 8'hFF, det_cnt)
        do_reset(1);
        det_thr = 8'h00;
        host.wr(REG_POLARITY_ERR, 8'h04);
        @(negedge clock);
        det_p = 1'b1;
        cor_p = 1'b1;
        @(negedge clock);
        det_p = 1'b0;
        cor_p = 1'b0;
        `CHK("auto_rise", 1'b1, err_out)
        repeat (AUTO_CLEAR_CYCLES_INT - 1) @(negedge clock);
        `CHK("auto_hold", 8'h01, det_cnt)
        `CHK("auto_hold_cor", 8'h01, cor_cnt)
        @(negedge clock);
        `CHK("auto_clear", 8'h00, det_cnt)
        `CHK("auto_clear_cor", 8'h00, cor_cnt)
        `CHK("auto_fall", 1'b0, err_out)
        end_sim();
    end
endmodule : tb
